/* rtl/dioc_pkg.sv */
// Purpose: shared constants of the digital I/O conditioning block
// Assumes: clk_sys at 200 MHz, delays held in whole milliseconds
// Notes: register byte address is four times the word index
package dioc_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int SCAN_MS = 5;
  localparam int SCAN_CYCLES_DEF = SCAN_MS * (CLK_HZ / 1000);
  localparam int AC_HOLD_MS = 30;
  localparam int DLY_MAX_MS = 1_800_000;
  localparam int DLY_W = 21;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH_DEF = 8;

  // word indices
  localparam logic [5:0] IDX_IN_NC = 6'h00;
  localparam logic [5:0] IDX_AC_EN = 6'h01;
  localparam logic [5:0] IDX_OUT_NC = 6'h02;
  localparam logic [5:0] IDX_ROUTE = 6'h03;
  localparam logic [5:0] IDX_OUT_CMD = 6'h04;
  localparam logic [5:0] IDX_IN_STATE = 6'h05;
  localparam logic [5:0] IDX_RELAY = 6'h06;
  localparam logic [5:0] IDX_DLY_BASE = 6'h08;

  // reset values: normally open inputs, alternating hold off, zero delays
  localparam logic [31:0] RST_IN_NC = 32'h0000_0000;
  localparam logic [31:0] RST_AC_EN = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_NC = 32'h0000_0000;
  localparam logic [31:0] RST_ROUTE = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_CMD = 32'h0000_0000;
  localparam logic [DLY_W-1:0] RST_DLY = 21'h00_0000;
endpackage : dioc_pkg

/* rtl/dioc_chan.sv */
// Purpose: one input channel: polarity, pick-up and drop-off qualification
// Assumes: scanTick is a one-cycle pulse every scan period
// Notes: delays resolve to whole scans, rounded up
`timescale 1ns/10ps
module dioc_chan
  import dioc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic scanTick, // scan pulse
  input wire logic fieldInput, // raw pin level
  input wire logic ncSel, // 1: normally closed
  input wire logic acEn, // alternating hold option
  input wire logic [DLY_W-1:0] actDly, // pick-up delay, ms
  input wire logic [DLY_W-1:0] dropDly, // drop-off delay, ms
  output logic qualState // qualified state
);
  logic [DLY_W:0] elapsed_r;
  logic [DLY_W:0] elapsed_nxt;
  logic qual_r;
  logic qual_nxt;
  logic level;
  logic [DLY_W:0] target;

  always_comb
  begin
    level = fieldInput ^ ncSel;
    // drop-off target widened by the hold so a zero crossing never releases
    target = qual_r ? ({1'b0, dropDly} + (acEn ? (DLY_W+1)'(AC_HOLD_MS) : '0))
                    : {1'b0, actDly};
    elapsed_nxt = elapsed_r;
    qual_nxt = qual_r;
    if (scanTick)
    begin
      if (level == qual_r)
        elapsed_nxt = '0;
      else if (elapsed_r >= target)
      begin
        qual_nxt = level;
        elapsed_nxt = '0;
      end
      else
        elapsed_nxt = elapsed_r + (DLY_W+1)'(SCAN_MS);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      elapsed_r <= '0;
      qual_r <= 1'b0;
    end
    else if (ce)
    begin
      elapsed_r <= elapsed_nxt;
      qual_r <= qual_nxt;
    end
  end

  assign qualState = qual_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence scanStep;
    scanTick && ce;
  endsequence

  AST_STABLE_OFF_SCAN: assert property (!(scanTick && ce) |=> $stable(qual_r))
    else $error("state moved outside a scan");
  AST_POLARITY: assert property (scanStep and (level != qual_r) and (target == '0)
      |=> qual_r == $past(fieldInput ^ ncSel))
    else $error("polarity not applied");
  AST_ZERO_PICKUP: assert property (scanStep and !qual_r and level and (actDly == '0)
      |=> qual_r)
    else $error("zero pick-up delay not immediate");
  AST_ZERO_DROP: assert property (scanStep and qual_r and !level and !acEn
      and (dropDly == '0) |=> !qual_r)
    else $error("zero drop-off delay not immediate");
  AST_AC_HOLD: assert property (scanStep and qual_r and acEn
      and (elapsed_r < (DLY_W+1)'(AC_HOLD_MS)) |=> qual_r)
    else $error("released inside alternating hold");
  AST_REVERT: assert property (scanStep and (level == qual_r)
      |=> (elapsed_r == '0) && $stable(qual_r))
    else $error("reverted change not discarded");
endmodule : dioc_chan

/* rtl/dioc_top.sv */
// Purpose: digital input scan and output relay drive with register port
// Assumes: pins synchronous to clk_sys; one-cycle register strobes
// Notes: output n may follow input n when its route bit is set
// What this block does
// - sample every input once per 5 ms scan.
// - per input, normally open or closed selects energized reading.
// - rising status waits a pick-up delay in ms, default zero.
// - falling status waits a separate drop-off delay, default zero.
// - alternating hold option adds 30 ms to drop-off, default off.
// - internal use of an input state lags one further scan.
// - routed input reaches its relay one scan after internal use.
// - supply loss or full reset opens every relay.
// - normally closed relays hold through communication or protection reset.
// - relay commands apply once per scan.
`timescale 1ns/10ps
module dioc_top
  import dioc_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
)
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // full system reset
  input wire logic ce, // clock enable
  input wire logic [NUM_CH-1:0] fieldInput, // energized input pins
  input wire logic auxLost, // auxiliary supply lost
  input wire logic commRst, // communication reset pulse
  input wire logic protRst, // protection reset pulse
  input wire logic [ADDR_W-1:0] regAddr, // byte address
  input wire logic [DATA_W-1:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [DATA_W-1:0] regRdata, // read data
  output logic [NUM_CH-1:0] inState, // input state for internal logic
  output logic [NUM_CH-1:0] outputRelay, // relay coil drive
  output logic scanPulse // scan marker
);
  localparam int CW = $clog2(SCAN_CYCLES);
  localparam logic [CW-1:0] CNT_LAST = CW'(SCAN_CYCLES - 1);

  logic [CW-1:0] scanCnt_r, scanCnt_nxt;
  logic scanTick_r, scanTick_nxt;
  logic [NUM_CH-1:0] inNc_r, inNc_nxt;
  logic [NUM_CH-1:0] altHoldOpt_r, altHoldOpt_nxt;
  logic [NUM_CH-1:0] outNc_r, outNc_nxt;
  logic [NUM_CH-1:0] route_r, route_nxt;
  logic [NUM_CH-1:0] outCmd_r, outCmd_nxt;
  logic [NUM_CH-1:0] inState_r, inState_nxt;
  logic [NUM_CH-1:0] relay_r, relay_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [DLY_W-1:0] actDly_r [NUM_CH];
  logic [DLY_W-1:0] actDly_nxt [NUM_CH];
  logic [DLY_W-1:0] dropDly_r [NUM_CH];
  logic [DLY_W-1:0] dropDly_nxt [NUM_CH];
  logic [NUM_CH-1:0] qual;
  logic [5:0] idx;
  logic [DLY_W-1:0] wrDly;

  always_comb
  begin
    scanCnt_nxt = scanCnt_r + CW'(1);
    scanTick_nxt = 1'b0;
    if (scanCnt_r == CNT_LAST)
    begin
      scanCnt_nxt = '0;
      scanTick_nxt = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : gChan
      dioc_chan u_dioc_chan (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .scanTick(scanTick_r),
        .fieldInput(fieldInput[g]),
        .ncSel(inNc_r[g]),
        .acEn(altHoldOpt_r[g]),
        .actDly(actDly_r[g]),
        .dropDly(dropDly_r[g]),
        .qualState(qual[g])
      );
    end
  endgenerate

  // register writes; an oversized delay is clamped to the longest setting
  always_comb
  begin
    idx = regAddr[ADDR_W-1:2];
    wrDly = (regWdata > DATA_W'(DLY_MAX_MS)) ? DLY_W'(DLY_MAX_MS) : regWdata[DLY_W-1:0];
    inNc_nxt = inNc_r;
    altHoldOpt_nxt = altHoldOpt_r;
    outNc_nxt = outNc_r;
    route_nxt = route_r;
    outCmd_nxt = outCmd_r;
    actDly_nxt = actDly_r;
    dropDly_nxt = dropDly_r;
    if (regWr)
    begin
      case (idx)
        IDX_IN_NC: inNc_nxt = regWdata[NUM_CH-1:0];
        IDX_AC_EN: altHoldOpt_nxt = regWdata[NUM_CH-1:0];
        IDX_OUT_NC: outNc_nxt = regWdata[NUM_CH-1:0];
        IDX_ROUTE: route_nxt = regWdata[NUM_CH-1:0];
        IDX_OUT_CMD: outCmd_nxt = regWdata[NUM_CH-1:0];
        default:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (idx == IDX_DLY_BASE + 6'(2 * i))
              actDly_nxt[i] = wrDly;
            if (idx == IDX_DLY_BASE + 6'(2 * i + 1))
              dropDly_nxt[i] = wrDly;
          end
        end
      endcase
    end
    if (commRst || protRst)
      outCmd_nxt = outCmd_nxt & outNc_r;
  end

  // scan pipeline and relay drive
  always_comb
  begin
    inState_nxt = inState_r;
    relay_nxt = relay_r;
    if (scanTick_r)
    begin
      inState_nxt = qual;
      for (int i = 0; i < NUM_CH; i++)
        relay_nxt[i] = route_r[i] ? inState_r[i] : outCmd_r[i];
    end
    if (commRst || protRst)
      relay_nxt = relay_nxt & outNc_r;
    if (auxLost)
      relay_nxt = '0;
  end

  always_comb
  begin
    rdata_nxt = '0;
    if (regRd)
    begin
      case (idx)
        IDX_IN_NC: rdata_nxt = DATA_W'(inNc_r);
        IDX_AC_EN: rdata_nxt = DATA_W'(altHoldOpt_r);
        IDX_OUT_NC: rdata_nxt = DATA_W'(outNc_r);
        IDX_ROUTE: rdata_nxt = DATA_W'(route_r);
        IDX_OUT_CMD: rdata_nxt = DATA_W'(outCmd_r);
        IDX_IN_STATE: rdata_nxt = DATA_W'(inState_r);
        IDX_RELAY: rdata_nxt = DATA_W'(relay_r);
        default:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (idx == IDX_DLY_BASE + 6'(2 * i))
              rdata_nxt = DATA_W'(actDly_r[i]);
            if (idx == IDX_DLY_BASE + 6'(2 * i + 1))
              rdata_nxt = DATA_W'(dropDly_r[i]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      scanCnt_r <= '0;
      scanTick_r <= 1'b0;
      inNc_r <= RST_IN_NC[NUM_CH-1:0];
      altHoldOpt_r <= RST_AC_EN[NUM_CH-1:0];
      outNc_r <= RST_OUT_NC[NUM_CH-1:0];
      route_r <= RST_ROUTE[NUM_CH-1:0];
      outCmd_r <= RST_OUT_CMD[NUM_CH-1:0];
      inState_r <= '0;
      relay_r <= '0;
      rdata_r <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        actDly_r[i] <= RST_DLY;
        dropDly_r[i] <= RST_DLY;
      end
    end
    else if (ce)
    begin
      scanCnt_r <= scanCnt_nxt;
      scanTick_r <= scanTick_nxt;
      inNc_r <= inNc_nxt;
      altHoldOpt_r <= altHoldOpt_nxt;
      outNc_r <= outNc_nxt;
      route_r <= route_nxt;
      outCmd_r <= outCmd_nxt;
      inState_r <= inState_nxt;
      relay_r <= relay_nxt;
      rdata_r <= rdata_nxt;
      actDly_r <= actDly_nxt;
      dropDly_r <= dropDly_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign inState = inState_r;
  assign outputRelay = relay_r;
  assign scanPulse = scanTick_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence scanStep;
    scanTick_r && ce;
  endsequence
  sequence quietStep;
    ce && !auxLost && !commRst && !protRst;
  endsequence

  // rising edge only: a pulse frozen by a low ce must not look like a second tick
  AST_SCAN_COUNT: assert property ($rose(scanTick_r) |-> $past(scanCnt_r) == CNT_LAST)
    else $error("scan pulse off period");
  AST_INT_LAG: assert property (scanStep |=> inState_r == $past(qual))
    else $error("internal state lag wrong");
  AST_ROUTE_LAG: assert property (scanStep and quietStep
      |=> relay_r == (($past(route_r) & $past(inState_r)) | (~$past(route_r) & $past(outCmd_r))))
    else $error("routed relay lag wrong");
  AST_AUX_OPEN: assert property ((auxLost && ce) |=> relay_r == '0)
    else $error("relay not opened on supply loss");
  AST_NC_HOLD: assert property (((commRst || protRst) && ce && !auxLost && !scanTick_r)
      |=> ((relay_r & $past(outNc_r)) == ($past(relay_r) & $past(outNc_r)))
      && ((relay_r & ~$past(outNc_r)) == '0))
    else $error("relay reset handling wrong");
  AST_RELAY_ON_SCAN: assert property ((!scanTick_r) and quietStep |=> $stable(relay_r))
    else $error("relay moved outside a scan");
endmodule : dioc_top

/* dv/dioc_field_model.sv */
// Purpose: field side model: contacts energize the block's input pins
// Assumes: contact commands change only right after a clk_sys rising edge
// Notes: pins lag the contacts one cycle, so changes land mid-scan
`timescale 1ns/10ps
module dioc_field_model
  import dioc_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
)
(
  input wire logic clk_sys, // system clock
  input wire logic [NUM_CH-1:0] contactClosed, // wanted contact state
  output logic [NUM_CH-1:0] fieldInput // energized pin levels
);
  always @(posedge clk_sys)
  begin
    fieldInput <= contactClosed;
  end
endmodule : dioc_field_model

/* dv/dioc_top_tb_top.sv */
// Purpose: self-checking bench of the digital I/O conditioning block
// Assumes: scan shortened to 20 cycles; delays still count 5 ms per scan
// Notes: ce is dropped once across a whole scan to show that state freezes
`timescale 1ns/10ps
module dioc_top_tb_top
  import dioc_pkg::*;
;
  localparam int SCAN = 20;
  logic clk_sys, srst, ce, auxLost, commRst, protRst, regWr, regRd, scanPulse;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic [NUM_CH_DEF-1:0] contact, fieldInput, inState, outputRelay;
  int failCount, checkCount, lastGap;

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  dioc_top #(.NUM_CH(NUM_CH_DEF), .SCAN_CYCLES(SCAN)) u_dioc_top (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .fieldInput(fieldInput),
    .auxLost(auxLost), .commRst(commRst), .protRst(protRst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .inState(inState), .outputRelay(outputRelay), .scanPulse(scanPulse));
  dioc_field_model #(.NUM_CH(NUM_CH_DEF)) u_dioc_field_model (
    .clk_sys(clk_sys), .contactClosed(contact), .fieldInput(fieldInput));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check("regRdata", regRdata, exp);
  endtask : reg_read

  // returns just after the edge that took a scan pulse; bounded wait
  task automatic wait_scan();
    lastGap = 0;
    do
    begin
      @(posedge clk_sys);
      lastGap++;
    end
    while (scanPulse !== 1'b1 && lastGap < 3 * SCAN);
    #1;
  endtask : wait_scan

  task automatic t_regs();
    logic [7:0] defs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24};
    foreach (defs[i]) reg_read(defs[i], 32'h0000_0000);
    reg_write(8'h1C, 32'h0000_00FF);
    reg_read(8'h1C, 32'h0000_0000);
    reg_write(8'h58, 32'h001F_FFFF);
    reg_read(8'h58, 32'h001B_7740);
    @(posedge clk_sys);
    #1;
    check("regRdata", regRdata, 32'h0000_0000);
    wait_scan();
    wait_scan();
    check("scan gap", lastGap, SCAN);
  endtask : t_regs

  task automatic t_polarity();
    wait_scan();
    reg_write(8'h00, 32'h0000_0002);
    reg_write(8'h0C, 32'h0000_0001);
    @(posedge clk_sys) contact <= 8'h01;
    for (int k = 1; k <= 3; k++)
    begin
      wait_scan();
      check("inState", inState[1:0], (k > 1) ? 2'b11 : 2'b00);
      check("outputRelay", outputRelay[0], k == 3);
    end
  endtask : t_polarity

  // channel 3 reverts after one scan and must never show
  task automatic t_delays();
    wait_scan();
    reg_write(8'h30, 32'h0000_000A);
    reg_write(8'h38, 32'h0000_000A);
    @(posedge clk_sys) contact <= contact | 8'h0C;
    for (int k = 1; k <= 4; k++)
    begin
      wait_scan();
      if (k == 1) @(posedge clk_sys) contact <= contact & 8'hF7;
      if (k >= 3) check("inState", inState[3:2], {1'b0, k == 4});
    end
  endtask : t_delays

  task automatic t_dropoff();
    wait_scan();
    reg_write(8'h34, 32'h0000_0005);
    reg_write(8'h04, 32'h0000_0001);
    @(posedge clk_sys) contact <= contact & 8'hFA;
    for (int k = 1; k <= 9; k++)
    begin
      wait_scan();
      if (k == 2 || k == 3) check("inState", inState[2], k == 2);
      if (k >= 6 && k <= 8) check("inState", inState[0], k < 8);
      if (k >= 8) check("outputRelay", outputRelay[0], k == 8);
    end
    reg_read(8'h14, 32'h0000_0002);
  endtask : t_dropoff

  task automatic t_relays();
    reg_write(8'h0C, 32'h0000_0000);
    reg_write(8'h08, 32'h0000_0010);
    for (int i = 0; i < 2; i++)
    begin
      reg_write(8'h10, 32'h0000_0030);
      #1;
      check("outputRelay", outputRelay[5:4], {1'b0, i == 1});
      wait_scan();
      check("outputRelay", outputRelay, 8'h30);
      @(posedge clk_sys);
      commRst <= (i == 0);
      protRst <= (i == 1);
      @(posedge clk_sys);
      commRst <= 1'b0;
      protRst <= 1'b0;
      #1;
      check("outputRelay", outputRelay, 8'h10);
    end
    reg_read(8'h10, 32'h0000_0010);
    reg_read(8'h18, 32'h0000_0010);
    // ce low over more than a scan: neither the write nor a scan may land
    @(posedge clk_sys) ce <= 1'b0;
    reg_write(8'h10, 32'h0000_0000);
    repeat (SCAN + 5) @(posedge clk_sys);
    #1;
    check("outputRelay", outputRelay, 8'h10);
    @(posedge clk_sys) ce <= 1'b1;
    reg_read(8'h10, 32'h0000_0010);
    // full reset while the normally closed relay is still held
    @(posedge clk_sys) srst <= 1'b1;
    @(posedge clk_sys) srst <= 1'b0;
    #1;
    check("outputRelay", outputRelay, 8'h00);
    reg_read(8'h10, 32'h0000_0000);
    reg_read(8'h08, 32'h0000_0000);
    reg_write(8'h10, 32'h0000_0030);
    wait_scan();
    check("outputRelay", outputRelay, 8'h30);
    @(posedge clk_sys) auxLost <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("outputRelay", outputRelay, 8'h00);
    @(posedge clk_sys) auxLost <= 1'b0;
  endtask : t_relays

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    auxLost = 1'b0;
    commRst = 1'b0;
    protRst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    contact = '0;
    failCount = 0;
    checkCount = 0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_polarity();
    t_delays();
    t_dropoff();
    t_relays();
    print_verdict();
  end

  // whole run needs about 30 scans; far beyond that means a hang
  initial
  begin
    repeat (20_000) @(posedge clk_sys);
    failCount++;
    $display("Error watchdog expected finish seen hang");
    print_verdict();
  end
endmodule : dioc_top_tb_top
